// ### verilog/occs_regs.svh
// Register offsets, field positions, reset values and codes for the oscillator control block.
// Assumes APB with 32-bit data; each register one aligned word.
`ifndef OCCS_REGS_SVH
`define OCCS_REGS_SVH

// ==========================================================
// Register map
`define OCCS_CTRL_ADDR 12'h000
`define OCCS_STAT_ADDR 12'h004
`define OCCS_ADDR_W 12

// ==========================================================
// Control register fields
`define OCCS_CTRL_PLL_BIT 7
`define OCCS_CTRL_FSEL_HI 6
`define OCCS_CTRL_FSEL_LO 3
`define OCCS_CTRL_SCS_HI 1
`define OCCS_CTRL_SCS_LO 0
`define OCCS_CTRL_WMASK 8'hFB
`define OCCS_FSEL_RST 4'h7
`define OCCS_SCS_RST 2'h0

// ==========================================================
// Status register fields
`define OCCS_ST_T1R 7
`define OCCS_ST_PLL_READY_FLAG 6
`define OCCS_ST_STARTUP_TIMEOUT_FLAG 5
`define OCCS_ST_HFR 4
`define OCCS_ST_HFL 3
`define OCCS_ST_MFR 2
`define OCCS_ST_LFR 1
`define OCCS_ST_HFS 0

// ==========================================================
// Start-up timer
`define OCCS_OST_COUNT 11'h400
`define OCCS_OST_W 11

// ==========================================================
// Frequency codes (output frequency in kHz)
`define OCCS_KHZ_W 16
`define OCCS_KHZ_31 16'h001F
`define OCCS_KHZ_62 16'h003E
`define OCCS_KHZ_125 16'h007D
`define OCCS_KHZ_250 16'h00FA
`define OCCS_KHZ_500 16'h01F4
`define OCCS_KHZ_1000 16'h03E8
`define OCCS_KHZ_2000 16'h07D0
`define OCCS_KHZ_4000 16'h0FA0
`define OCCS_KHZ_8000 16'h1F40
`define OCCS_KHZ_16000 16'h3E80
`define OCCS_KHZ_32000 16'h7D00

`endif

// ### verilog/occs_pkg.sv
// Types shared by the oscillator control block.
// Assumes occs_regs.svh is on the include path.
package occs_pkg;

    // ==========================================================
    // Internal oscillator source
    typedef enum logic [1:0] {
        OCCS_SRC_LF,
        OCCS_SRC_MF,
        OCCS_SRC_HF
    } occs_src_t;

    // System clock source
    typedef enum logic [1:0] {
        OCCS_SYS_CONFIG,
        OCCS_SYS_TMR1,
        OCCS_SYS_INTERNAL
    } occs_sys_t;

    // Control register content
    typedef struct packed {
        logic soft_pll_on;
        logic [3:0] int_freq_sel;
        logic [1:0] sys_clk_sel;
    } occs_ctrl_t;

    // Oscillator readiness inputs
    typedef struct packed {
        logic tmr1_osc_on;
        logic tmr1_osc_ready;
        logic pll_locked;
        logic hf_ready;
        logic hf_2pct;
        logic mf_ready;
        logic lf_ready;
        logic hf_half_pct;
    } occs_osc_t;

    // Decoded clock selection
    typedef struct packed {
        occs_src_t src;
        logic [15:0] khz;
        logic pll_on;
    } occs_sel_t;

endpackage

// ### verilog/occs_startup.sv
// Start-up timer: counts external oscillator cycles before switchover.
// Assumes ext_tick_in is a one-cycle pulse per external oscillation, synchronous to clock_in.
`include "occs_regs.svh"

module occs_startup #(
    parameter int COUNT_W = `OCCS_OST_W
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Control
    input wire logic arm_in,
    input wire logic sleep_in,
    input wire logic ext_tick_in,
    // Status
    output logic done_out
);

    typedef struct packed {
        logic [COUNT_W-1:0] cnt;
        logic done;
    } occs_ost_state_t;

    occs_ost_state_t st_r;
    occs_ost_state_t st_nxt;

    // ==========================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        if (!arm_in || sleep_in) begin
            // Sleep or disarm aborts the count and clears done
            st_nxt.cnt = '0;
            st_nxt.done = 1'b0;
        end else if (!st_r.done && ext_tick_in) begin
            if (st_r.cnt == COUNT_W'(`OCCS_OST_COUNT - 1)) begin
                st_nxt.done = 1'b1;
            end
            st_nxt.cnt = st_r.cnt + COUNT_W'(1);
        end
    end

    // State register
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign done_out = st_r.done;

endmodule

// ### verilog/occs_top.sv
// Oscillator control and status registers with APB slave.
// Assumes APB master on clock_in; oscillator status inputs synchronous to clock_in.
// Assumes fuse inputs stay static while the part runs.
// Overview of operation
// - Codes 000x,0010,0011 give 31 kHz range
// - Codes 0100-0111 give MF 62.5-500 kHz
// - Codes 1000-1101,1111 give HF frequencies
// - Code 1110 gives 8 MHz, 32 with PLL
// - Clock select: 1x internal, 01 Timer1, 00 config
// - Unimplemented bits read zero, ignore writes
// - Status register fully read-only
// - Timer1 ready reflects oscillator or always one
// - PLL ready bit follows PLL lock while the PLL is enabled
// - Timeout bit shows running from config clock
// - HF ready bit follows oscillator
// - HF locked bit means 2% accuracy
// - MF ready bit follows oscillator
// - LF ready bit follows oscillator
// - HF stable bit means 0.5% accuracy
// - Timeout set after 1024 start-up counts
//
// Design decisions made here: the placing of the registers and register access over APB.
`include "occs_regs.svh"

module occs_top #(
    parameter int ADDR_W = `OCCS_ADDR_W
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Configuration fuses
    input wire logic fuse_pll_force_in,
    input wire logic [2:0] fuse_osc_mode_in,
    input wire logic fuse_two_speed_in,
    // Oscillator state
    input wire occs_pkg::occs_osc_t osc_in,
    input wire logic ext_tick_in,
    input wire logic sleep_in,
    // Clock selection outputs
    output logic pll_enable_out,
    output occs_pkg::occs_sys_t sys_src_out,
    output occs_pkg::occs_src_t int_src_out,
    output logic [`OCCS_KHZ_W-1:0] int_khz_out,
    output logic [2:0] osc_mode_out
);

    // ==========================================================
    // Block state
    // All registers of the block except the start-up timer's live in one struct;
    // the next value is built whole every cycle.
    // Bus, status and selection outputs are all fields.
    typedef struct packed {
        occs_pkg::occs_ctrl_t ctrl;
        logic [7:0] status;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic pll_en;
        occs_pkg::occs_sys_t sys;
        occs_pkg::occs_sel_t sel;
        logic [2:0] mode;
    } occs_state_t;

    occs_state_t st_r;
    occs_state_t st_nxt;

    logic ost_done;
    logic ost_arm;
    logic access;
    logic hit_ctrl;
    logic hit_stat;
    logic [7:0] ctrl_bits;
    logic pll_eff;

    // ==========================================================
    // Start-up timer arms when two-speed start applies
    // Leaving select 00 drops the arm and clears the
    // count, so each return to 00 starts a fresh count.
    assign ost_arm = fuse_two_speed_in && (st_r.ctrl.sys_clk_sel == 2'h0);

    // Sleep aborts a count in progress and keeps the
    // timeout flag clear until a full count completes.
    // start-up count
    occs_startup #(
        .COUNT_W(`OCCS_OST_W)
    ) u_startup (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .arm_in(ost_arm),
        .sleep_in(sleep_in),
        .ext_tick_in(ext_tick_in),
        .done_out(ost_done)
    );

    // Bus decode
    // Access is taken once per transfer: the ready flop
    // blocks a second take while the master still holds
    // psel and penable at the edge it samples pready.
    // Offsets outside the two words answer with an error.
    assign access = psel_in && penable_in && !st_r.ready;
    assign hit_ctrl = paddr_in == ADDR_W'(`OCCS_CTRL_ADDR);
    assign hit_stat = paddr_in == ADDR_W'(`OCCS_STAT_ADDR);

    // The gap bit is never stored; it is rebuilt as zero
    // here so a read can not leak written data.
    // bit 2 reads zero
    assign ctrl_bits = {st_r.ctrl.soft_pll_on, st_r.ctrl.int_freq_sel, 1'b0, st_r.ctrl.sys_clk_sel};

    // The software bit keeps its written value under the
    // fuse, so clearing the fuse restores its meaning.
    // fuse overrides software
    assign pll_eff = fuse_pll_force_in || st_r.ctrl.soft_pll_on;

    // ==========================================================
    // Frequency decode
    // Maps the select code to source and rate in kHz.
    // Fractional rates are truncated: 31.25 shows as 31
    // and 62.5 as 62. Code 1010 gives the high oscillator
    // at 500 kHz. The 32 MHz rate needs the PLL both
    // enabled and locked, so a slow lock keeps 8 MHz.
    function automatic occs_pkg::occs_sel_t decode_freq(input logic [3:0] code, input logic pll);
        occs_pkg::occs_sel_t s;
        s.pll_on = 1'b0;
        s.src = occs_pkg::OCCS_SRC_HF;
        s.khz = `OCCS_KHZ_31;
        case (code)
            // Slow codes keep the 31 kHz default rate
            // slow codes
            4'h0, 4'h1: begin
                s.src = occs_pkg::OCCS_SRC_LF;
            end
            4'h2: begin
                s.src = occs_pkg::OCCS_SRC_MF;
            end
            4'h3: begin
                s.src = occs_pkg::OCCS_SRC_HF;
            end
            4'h4: begin
                s.src = occs_pkg::OCCS_SRC_MF;
                s.khz = `OCCS_KHZ_62;
            end
            4'h5: begin
                s.src = occs_pkg::OCCS_SRC_MF;
                s.khz = `OCCS_KHZ_125;
            end
            4'h6: begin
                s.src = occs_pkg::OCCS_SRC_MF;
                s.khz = `OCCS_KHZ_250;
            end
            4'h7: begin
                s.src = occs_pkg::OCCS_SRC_MF;
                s.khz = `OCCS_KHZ_500;
            end
            // These use the high oscillator default source
            // high oscillator codes
            4'h8: begin
                s.khz = `OCCS_KHZ_125;
            end
            4'h9: begin
                s.khz = `OCCS_KHZ_250;
            end
            4'hA: begin
                s.khz = `OCCS_KHZ_500;
            end
            4'hB: begin
                s.khz = `OCCS_KHZ_1000;
            end
            4'hC: begin
                s.khz = `OCCS_KHZ_2000;
            end
            4'hD: begin
                s.khz = `OCCS_KHZ_4000;
            end
            // Only this code may use the PLL output
            // PLL multiplies 8 MHz
            4'hE: begin
                s.khz = pll ? `OCCS_KHZ_32000 : `OCCS_KHZ_8000;
                s.pll_on = pll;
            end
            4'hF: begin
                s.khz = `OCCS_KHZ_16000;
            end
            default: begin
                s.khz = `OCCS_KHZ_31;
            end
        endcase
        return s;
    endfunction

    // ==========================================================
    // Next state
    // Every access costs one wait state: the take edge
    // registers ready, read data and error together so
    // all three leave flip-flops in the same cycle.
    // Writes land at the take edge, one edge before the master samples pready.
    // Status bits are sampled every cycle; a read shows
    // the inputs one cycle older than the read data.
    always_comb begin
        st_nxt = st_r;
        // Ready and error are one-cycle pulses
        st_nxt.ready = 1'b0;
        st_nxt.err = 1'b0;
        // Bus access phase, one wait cycle then ready
        if (access) begin
            st_nxt.ready = 1'b1;
            // Unmapped offsets answer with error and zero data
            st_nxt.err = !(hit_ctrl || hit_stat);
            st_nxt.rdata = 32'h0;
            if (pwrite_in) begin
                // Lane 0 strobe gates the whole register
                // masked write, status ignores writes
                if (hit_ctrl && pstrb_in[0]) begin
                    st_nxt.ctrl.soft_pll_on = pwdata_in[`OCCS_CTRL_PLL_BIT];
                    st_nxt.ctrl.int_freq_sel = pwdata_in[`OCCS_CTRL_FSEL_HI:`OCCS_CTRL_FSEL_LO];
                    st_nxt.ctrl.sys_clk_sel = pwdata_in[`OCCS_CTRL_SCS_HI:`OCCS_CTRL_SCS_LO];
                end
            end else if (hit_ctrl) begin
                st_nxt.rdata = {24'h0, ctrl_bits & `OCCS_CTRL_WMASK};
            end else if (hit_stat) begin
                st_nxt.rdata = {24'h0, st_r.status};
            end
        end
        // Status inputs are levels; no edge is detected
        // Timer1 ready, always one when off
        st_nxt.status[`OCCS_ST_T1R] = osc_in.tmr1_osc_on ? osc_in.tmr1_osc_ready : 1'b1;
        st_nxt.status[`OCCS_ST_PLL_READY_FLAG] = pll_eff && osc_in.pll_locked;
        st_nxt.status[`OCCS_ST_STARTUP_TIMEOUT_FLAG] = (st_r.ctrl.sys_clk_sel == 2'h0) && (!fuse_two_speed_in || ost_done);
        st_nxt.status[`OCCS_ST_HFR] = osc_in.hf_ready;
        st_nxt.status[`OCCS_ST_HFL] = osc_in.hf_2pct;
        st_nxt.status[`OCCS_ST_MFR] = osc_in.mf_ready;
        st_nxt.status[`OCCS_ST_LFR] = osc_in.lf_ready;
        st_nxt.status[`OCCS_ST_HFS] = osc_in.hf_half_pct;
        // Select 00 with two-speed start stays on the
        // internal block until the start-up count ends,
        // so the clock never leaves for an unproven source.
        // system clock select
        if (st_r.ctrl.sys_clk_sel[1]) begin
            st_nxt.sys = occs_pkg::OCCS_SYS_INTERNAL;
        end else if (st_r.ctrl.sys_clk_sel[0]) begin
            st_nxt.sys = occs_pkg::OCCS_SYS_TMR1;
        end else if (!st_nxt.status[`OCCS_ST_STARTUP_TIMEOUT_FLAG]) begin
            // Internal clock runs until start-up completes
            st_nxt.sys = occs_pkg::OCCS_SYS_INTERNAL;
        end else begin
            st_nxt.sys = occs_pkg::OCCS_SYS_CONFIG;
        end
        st_nxt.pll_en = pll_eff;
        st_nxt.sel = decode_freq(st_r.ctrl.int_freq_sel, pll_eff && osc_in.pll_locked);
        st_nxt.mode = fuse_osc_mode_in;
    end

    // ==========================================================
    // State register
    // Reset loads the visible defaults directly, so the
    // first read after release needs no settling cycle.
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            st_r <= '0;
            st_r.ctrl.int_freq_sel <= `OCCS_FSEL_RST;
            st_r.ctrl.sys_clk_sel <= `OCCS_SCS_RST;
            // Timer1 ready reads one at reset
            st_r.status[`OCCS_ST_T1R] <= 1'b1;
            // Selection outputs match the reset control value
            st_r.sel.src <= occs_pkg::OCCS_SRC_MF;
            st_r.sel.khz <= `OCCS_KHZ_500;
            st_r.sys <= occs_pkg::OCCS_SYS_INTERNAL;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs from state flip-flops
    // No output passes through logic after the state
    // register, which keeps pin timing independent of
    // the bus decode and the fuse inputs.
    assign prdata_out = st_r.rdata;
    assign pready_out = st_r.ready;
    assign pslverr_out = st_r.err;
    assign pll_enable_out = st_r.pll_en;
    assign sys_src_out = st_r.sys;
    assign int_src_out = st_r.sel.src;
    assign int_khz_out = st_r.sel.khz;
    assign osc_mode_out = st_r.mode;

endmodule

// ### bench/occs_props.sv
// Checker for the oscillator control block ports.
// Assumes it is bound to occs_top and sees only its ports.
`include "occs_regs.svh"

module occs_props #(
    parameter int ADDR_W = 12
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic fuse_pll_force_in,
    input wire occs_pkg::occs_osc_t osc_in,
    input wire logic pll_enable_out,
    input wire occs_pkg::occs_sys_t sys_src_out,
    input wire logic [15:0] int_khz_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    // ==========================================================
    // Steps of a transfer
    sequence s_access;
        psel_in && penable_in && !pready_out;
    endsequence
    sequence s_ctrl_wr;
        pready_out && pwrite_in && pstrb_in[0] && paddr_in == `OCCS_CTRL_ADDR;
    endsequence
    sequence s_stat_rd;
        pready_out && !pwrite_in && paddr_in == `OCCS_STAT_ADDR && osc_in == $past(osc_in)
            && osc_in == $past(osc_in, 2);
    endsequence

    // ==========================================================
    // Assertions
    AST_ANSWER: assert property (s_access |=> pready_out) else $error("access not answered");
    AST_PULSE: assert property (pready_out |=> !pready_out) else $error("ready longer than one cycle");
    AST_ERR_MAP: assert property (pslverr_out |-> pready_out && paddr_in != `OCCS_CTRL_ADDR
        && paddr_in != `OCCS_STAT_ADDR) else $error("error on mapped address");
    AST_FUSE_PLL: assert property (fuse_pll_force_in |=> pll_enable_out) else $error("fuse not forcing pll");
    AST_CTRL_GAP: assert property (pready_out && !pwrite_in && paddr_in == `OCCS_CTRL_ADDR
        |-> prdata_out[31:8] == 24'h000000 && !prdata_out[2]) else $error("control gap bits set");
    AST_T1_ALWAYS: assert property (s_stat_rd ##0 !osc_in.tmr1_osc_on |-> prdata_out[7])
        else $error("timer1 ready not forced");
    AST_STAT_IN: assert property (s_stat_rd |-> prdata_out[4:0] == osc_in[4:0])
        else $error("status bits not following oscillators");
    AST_SEL_TMR1: assert property (s_ctrl_wr ##0 pwdata_in[1:0] == 2'h1
        |-> ##[0:3] sys_src_out == occs_pkg::OCCS_SYS_TMR1) else $error("timer1 select not applied");
    AST_HF16: assert property (s_ctrl_wr ##0 pwdata_in[6:3] == 4'hF
        |-> ##[0:3] int_khz_out == `OCCS_KHZ_16000) else $error("16 MHz code not applied");
endmodule

bind occs_top occs_props #(.ADDR_W(ADDR_W)) u_props (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .fuse_pll_force_in(fuse_pll_force_in), .osc_in(osc_in), .pll_enable_out(pll_enable_out),
    .sys_src_out(sys_src_out), .int_khz_out(int_khz_out));

// ### bench/occs_top_tb.sv
// Self-checking bench for the oscillator control block.
// Assumes occs_pkg and occs_regs.svh are compiled first.
`include "occs_regs.svh"

module occs_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_in, rst_in, psel, penable, pwrite, e, fuse_pll, fuse_ts, tick, sleep, pready, pslverr, pll_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    logic [2:0] fmode;
    logic [2:0] omode;
    occs_pkg::occs_osc_t osc;
    occs_pkg::occs_sys_t sys_src;
    occs_pkg::occs_src_t int_src;
    logic [15:0] khz;
    int mismatches, n_compared, cycles;
    localparam logic [15:0] KT[16] = '{`OCCS_KHZ_31, `OCCS_KHZ_31, `OCCS_KHZ_31, `OCCS_KHZ_31,
        `OCCS_KHZ_62, `OCCS_KHZ_125, `OCCS_KHZ_250, `OCCS_KHZ_500, `OCCS_KHZ_125, `OCCS_KHZ_250,
        `OCCS_KHZ_500, `OCCS_KHZ_1000, `OCCS_KHZ_2000, `OCCS_KHZ_4000, `OCCS_KHZ_8000, `OCCS_KHZ_16000};
    localparam logic [1:0] ST[16] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1,
        2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2};

    // ==========================================================
    // Design under test
    occs_top dut (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .fuse_pll_force_in(fuse_pll), .fuse_osc_mode_in(fmode),
        .fuse_two_speed_in(fuse_ts), .osc_in(osc), .ext_tick_in(tick), .sleep_in(sleep),
        .pll_enable_out(pll_en), .sys_src_out(sys_src), .int_src_out(int_src), .int_khz_out(khz),
        .osc_mode_out(omode));

    // ==========================================================
    // Clock and hang guard
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 10000) begin
            mismatches++;
            conclude();
        end
    end

    // ==========================================================
    // Shared tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_in);
        penable <= 1'b1;
        do begin
            @(posedge clock_in);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        if (n >= 16) chk(32'h0, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task pulse(input logic to_tick);
        if (to_tick) tick <= 1'b1;
        else sleep <= 1'b1;
        @(posedge clock_in);
        tick <= 1'b0;
        sleep <= 1'b0;
        @(posedge clock_in);
    endtask
    task conclude();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task t_reset();
        apb(1'b0, `OCCS_CTRL_ADDR, 32'h0);
        chk(q, 32'h00000038);
        chk(32'(int_src), 32'(occs_pkg::OCCS_SRC_MF));
        apb(1'b1, `OCCS_STAT_ADDR, 32'h000000FF);
        chk(32'(e), 32'h0);
        apb(1'b0, `OCCS_STAT_ADDR, 32'h0);
        chk(q, 32'h00000080);
    endtask
    task t_freq();
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, `OCCS_CTRL_ADDR, {25'h0, 4'(i), 3'h2});
            repeat (3) @(posedge clock_in);
            chk(32'(khz), 32'(KT[i]));
            chk(32'(int_src), 32'(ST[i]));
        end
    endtask
    task t_pll();
        osc <= 8'h20;
        apb(1'b1, `OCCS_CTRL_ADDR, 32'h000000F2);
        repeat (3) @(posedge clock_in);
        chk({pll_en, khz}, {1'b1, `OCCS_KHZ_32000});
        apb(1'b0, `OCCS_STAT_ADDR, 32'h0);
        chk(q, 32'h000000C0);
        apb(1'b1, `OCCS_CTRL_ADDR, 32'h00000072);
        repeat (3) @(posedge clock_in);
        chk({pll_en, khz}, {1'b0, `OCCS_KHZ_8000});
        fuse_pll <= 1'b1;
        repeat (3) @(posedge clock_in);
        chk({pll_en, khz}, {1'b1, `OCCS_KHZ_32000});
        fuse_pll <= 1'b0;
    endtask
    task t_bits();
        apb(1'b1, `OCCS_CTRL_ADDR, 32'hFFFFFFFF);
        apb(1'b0, `OCCS_CTRL_ADDR, 32'h0);
        chk(q, 32'h000000FB);
        pstrb <= 4'hE;
        apb(1'b1, `OCCS_CTRL_ADDR, 32'h0);
        pstrb <= 4'hF;
        apb(1'b0, `OCCS_CTRL_ADDR, 32'h0);
        chk(q, 32'h000000FB);
        apb(1'b0, 12'h008, 32'h0);
        chk(32'(e), 32'h1);
        chk(q, 32'h0);
    endtask
    task automatic t_status();
        logic [7:0] p[5] = '{8'h00, 8'hFF, 8'h5A, 8'hA5, 8'h40};
        apb(1'b1, `OCCS_CTRL_ADDR, 32'h00000012);
        foreach (p[i]) begin
            osc <= p[i];
            repeat (3) @(posedge clock_in);
            apb(1'b0, `OCCS_STAT_ADDR, 32'h0);
            chk(q, {24'h0, ~p[i][7] | p[i][6], 2'h0, p[i][4:0]});
        end
    endtask
    task t_sel();
        apb(1'b1, `OCCS_CTRL_ADDR, 32'h0000007B);
        repeat (3) @(posedge clock_in);
        chk(32'(sys_src), 32'(occs_pkg::OCCS_SYS_INTERNAL));
        apb(1'b1, `OCCS_CTRL_ADDR, 32'h00000079);
        repeat (3) @(posedge clock_in);
        chk(32'(sys_src), 32'(occs_pkg::OCCS_SYS_TMR1));
        pulse(1'b0);
        apb(1'b1, `OCCS_CTRL_ADDR, 32'h00000078);
        repeat (1023) pulse(1'b1);
        repeat (3) @(posedge clock_in);
        chk(32'(sys_src), 32'(occs_pkg::OCCS_SYS_INTERNAL));
        pulse(1'b1);
        repeat (3) @(posedge clock_in);
        chk(32'(sys_src), 32'(occs_pkg::OCCS_SYS_CONFIG));
        apb(1'b0, `OCCS_STAT_ADDR, 32'h0);
        chk(32'(q[5]), 32'h1);
        pulse(1'b0);
        apb(1'b0, `OCCS_STAT_ADDR, 32'h0);
        chk(32'(q[5]), 32'h0);
        fuse_ts <= 1'b0;
        fmode <= 3'h5;
        repeat (3) @(posedge clock_in);
        chk(32'(sys_src), 32'(occs_pkg::OCCS_SYS_CONFIG));
        chk(32'(omode), 32'h00000005);
        apb(1'b0, `OCCS_STAT_ADDR, 32'h0);
        chk(32'(q[5]), 32'h1);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {rst_in, fuse_ts, pstrb} = 6'h3F;
        {psel, penable, pwrite, paddr, pwdata, fuse_pll, fmode, osc, tick, sleep} = '0;
        repeat (8) @(posedge clock_in);
        rst_in <= 1'b0;
        t_reset();
        t_freq();
        t_pll();
        t_bits();
        t_status();
        t_sel();
        conclude();
    end
endmodule
